// ---- tsc_clock_path.sv ----
// Package of shared constants, and the clock source select / prescaler path
`timescale 1ns/1ps

package tsc_pkg;
  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_FLAGS = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 4'h4;
  // ----------------------------------------------------------------
  // Field positions of timer_status_control
  // ----------------------------------------------------------------
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_OVF_IRQ_EN = 6;
  localparam int BIT_CENTER_ALIGN = 5;
  localparam int CLKSEL_HI = 4;
  localparam int CLKSEL_LO = 3;
  localparam int PRESCALE_HI = 2;
  localparam int PRESCALE_LO = 0;
  // Overflow sits at the same bit in the flag/enable/status/clear layout
  localparam int NUM_CHAN_MAX = 7;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CLKSEL_RST = 2'h0;
  localparam logic [2:0] PRESCALE_RST = 3'h0;
  localparam logic BIT_RST = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 8'h00;
  // ----------------------------------------------------------------
  // Clock source encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSC_SRC_OFF = 2'b00,
    TSC_SRC_BUS = 2'b01,
    TSC_SRC_FIXED = 2'b10,
    TSC_SRC_EXT = 2'b11
  } tsc_clk_src_t;
  localparam int PRESCALE_CNT_W = 7;
endpackage : tsc_pkg

module tsc_clock_path
  import tsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control from the register file
  input wire logic [1:0] clockSourceSelect,
  input wire logic [2:0] prescaleSelect,
  // Clock sources
  input wire logic extClkPin,
  input wire logic fixedClkTick,
  input wire logic fixedClkActive,
  // Prescaled count enable
  output logic countTick
);
  // ----------------------------------------------------------------
  // External source synchroniser
  // ----------------------------------------------------------------
  logic [2:0] extSync_ff;
  logic extLevel_ff;
  logic [PRESCALE_CNT_W-1:0] preCnt_ff;
  wire logic extAgree = (extSync_ff[1] == extSync_ff[2]);
  wire logic extRise = extAgree && extSync_ff[2] && !extLevel_ff;
  // Fixed clock only differs from bus rate when a PLL/FLL is up
  wire logic fixedEff = fixedClkActive ? fixedClkTick : 1'b1;
  logic srcTick;
  always_comb begin
    case (tsc_clk_src_t'(clockSourceSelect))
      TSC_SRC_OFF: srcTick = 1'b0;
      TSC_SRC_BUS: srcTick = 1'b1;
      TSC_SRC_FIXED: srcTick = fixedEff;
      TSC_SRC_EXT: srcTick = extRise;
      default: srcTick = 1'b0;
    endcase
  end
  // Mask is taken straight from the register, so a new factor acts next cycle
  wire logic [PRESCALE_CNT_W-1:0] preMask =
    PRESCALE_CNT_W'((8'h01 << prescaleSelect) - 8'h01);
  wire logic preDone = ((preCnt_ff & preMask) == preMask);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extSync_ff <= '0;
      extLevel_ff <= BIT_RST;
      preCnt_ff <= '0;
      countTick <= BIT_RST;
    end else begin
      extSync_ff <= {extSync_ff[1:0], extClkPin};
      if (extAgree) begin
        extLevel_ff <= extSync_ff[2];
      end
      if (srcTick) begin
        preCnt_ff <= preDone ? '0 : preCnt_ff + 1'b1;
      end
      countTick <= srcTick && preDone;
    end
  end
endmodule : tsc_clock_path

// ---- tsc_timer_status_control.sv ----
// Status/control register, event flags and interrupt request of the timer unit
//
// Summary of operation
// - Overflow flag sets when the counter wraps to 0x0000 past the modulo value.
// - Any flag clears only by a read while set, then a zero write; the clear register clears a flag by a one write after the read.
// - A new event between read and zero write restarts the clear sequence.
// - Writing one to the overflow flag bit leaves it unchanged.
// - Overflow interrupt enable, bit 6, gates overflow request; reset clears it.
// - Interrupt request is a level, high while an enabled flag is one.
// - The interrupt request output is active high.
// - Capture or compare events set per-channel flags; per-channel enables gate their requests.
// - Bit 5 selects center-aligned up/down PWM for all channels; reset clears.
// - Two-bit source field disables timer or picks one of three clocks.
// - External clock is synchronised to the bus clock before the prescaler.
// - Without active PLL/FLL the fixed clock equals the bus clock.
// - Three-bit prescale field picks one of eight power-of-two divisions.
// - A new prescale factor acts from the next clock after the update.
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps

module tsc_timer_status_control
  import tsc_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [tsc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tsc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [tsc_pkg::DATA_W-1:0] regRdata,
  // Events from counter and channel datapaths
  input wire logic overflowEvent,
  input wire logic [NUM_CHAN-1:0] channelEvent,
  // Clock sources
  input wire logic extClkPin,
  input wire logic fixedClkTick,
  input wire logic fixedClkActive,
  // Controls towards the counter and channels
  output logic countTick,
  output logic centerAlignSelect,
  output logic [1:0] clockSourceSelect,
  output logic [2:0] prescaleSelect,
  // Interrupt
  output logic irq
);
  import tsc_pkg::*;

  // ----------------------------------------------------------------
  // Flag layout helpers
  // ----------------------------------------------------------------
  // Flag vector index NUM_CHAN is the overflow flag, the rest are channels.
  localparam int NFLAG = NUM_CHAN + 1;
  localparam int OVF = NUM_CHAN;

  // Place the flag vector into the common byte layout (overflow at bit 7)
  function automatic logic [DATA_W-1:0] toLayout(input logic [NFLAG-1:0] v);
    logic [DATA_W-1:0] b;
    b = '0;
    b[NUM_CHAN-1:0] = v[NUM_CHAN-1:0];
    b[BIT_OVF_FLAG] = v[OVF];
    return b;
  endfunction : toLayout

  // Pull a byte in the common layout back into the flag vector order
  function automatic logic [NFLAG-1:0] fromLayout(input logic [DATA_W-1:0] b);
    logic [NFLAG-1:0] v;
    v = '0;
    v[NUM_CHAN-1:0] = b[NUM_CHAN-1:0];
    v[OVF] = b[BIT_OVF_FLAG];
    return v;
  endfunction : fromLayout

  // Flags held by a register: overflow at the control register, channels at
  // the channel register, all of them at the status and clear registers
  function automatic logic [NFLAG-1:0] flagMask(
    input logic atSc,
    input logic atChan,
    input logic atAll
  );
    logic [NFLAG-1:0] m;
    m = '0;
    if (atSc) begin
      m[OVF] = 1'b1;
    end
    if (atChan) begin
      m[NUM_CHAN-1:0] = '1;
    end
    if (atAll) begin
      m = '1;
    end
    return m;
  endfunction : flagMask

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic ovfIrqEn_ff;
  logic centerAlign_ff;
  logic [1:0] clkSel_ff;
  logic [2:0] prescale_ff;
  logic [NUM_CHAN-1:0] chanIrqEn_ff;
  logic [NFLAG-1:0] flag_ff;
  logic [NFLAG-1:0] armed_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [NFLAG-1:0] nxt_flag;
  logic [NFLAG-1:0] nxt_armed;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Strobes never come together, so one decode serves reads and writes
  wire logic selSc = (regAddr == ADDR_STATUS_CONTROL);
  wire logic selChan = (regAddr == ADDR_CHAN_FLAGS);
  wire logic selEn = (regAddr == ADDR_IRQ_ENABLE);
  wire logic selStat = (regAddr == ADDR_IRQ_STATUS);
  wire logic selClr = (regAddr == ADDR_IRQ_CLEAR);

  wire logic wrSc = regWr && selSc;
  wire logic wrChan = regWr && selChan;
  wire logic wrEn = regWr && selEn;
  wire logic wrClr = regWr && selClr;

  // ----------------------------------------------------------------
  // Events and clear requests per flag
  // ----------------------------------------------------------------
  wire logic [NFLAG-1:0] eventVec = {overflowEvent, channelEvent};

  // Which flags a read of this address shows (the arming step)
  wire logic [NFLAG-1:0] readShows = flagMask(selSc, selChan, selStat);
  wire logic [NFLAG-1:0] readArm = (regRd ? readShows : '0) & flag_ff;

  // Zero-write step: a zero at the flag bit of its own register, or a one
  // in the clear register. Both still need the arming read first.
  wire logic [NFLAG-1:0] wrData = fromLayout(regWdata);
  wire logic [NFLAG-1:0] zeroWr =
    (wrSc ? ~wrData & (NFLAG'(1) << OVF) : '0) |
    (wrChan ? ~wrData & {1'b0, {NUM_CHAN{1'b1}}} : '0) |
    (wrClr ? wrData : '0);
  // Any write to the control, channel or clear register holding the flag ends the pending sequence
  wire logic [NFLAG-1:0] wrTouches = flagMask(wrSc, wrChan, wrClr);

  // ----------------------------------------------------------------
  // Two-step clear, one copy per flag
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : gFlag
      always_comb begin
        nxt_flag[gi] = flag_ff[gi];
        nxt_armed[gi] = armed_ff[gi];
        if (eventVec[gi]) begin
          // Set wins over a clear in the same cycle, and the read must be redone
          nxt_flag[gi] = 1'b1;
          nxt_armed[gi] = 1'b0;
        end else if (zeroWr[gi] && armed_ff[gi]) begin
          nxt_flag[gi] = 1'b0;
          nxt_armed[gi] = 1'b0;
        end else if (wrTouches[gi]) begin
          nxt_armed[gi] = 1'b0;
        end else if (readArm[gi]) begin
          nxt_armed[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  wire logic [DATA_W-1:0] scView = {
    flag_ff[OVF], ovfIrqEn_ff, centerAlign_ff, clkSel_ff, prescale_ff};
  wire logic [DATA_W-1:0] enView =
    toLayout({ovfIrqEn_ff, chanIrqEn_ff});
  wire logic [DATA_W-1:0] chanView =
    toLayout({1'b0, flag_ff[NUM_CHAN-1:0]});
  wire logic [DATA_W-1:0] statView = toLayout(flag_ff);
  // The clear register holds no state of its own and reads as zero
  wire logic [DATA_W-1:0] readMux =
    selSc ? scView :
    selChan ? chanView :
    selEn ? enView :
    selStat ? statView :
    UNMAPPED_RDATA;

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  wire logic [NFLAG-1:0] enWrVec = fromLayout(regWdata);
  wire logic nxt_ovfIrqEn =
    wrSc ? regWdata[BIT_OVF_IRQ_EN] :
    wrEn ? enWrVec[OVF] : ovfIrqEn_ff;
  wire logic nxt_centerAlign =
    wrSc ? regWdata[BIT_CENTER_ALIGN] : centerAlign_ff;
  wire logic [1:0] nxt_clkSel =
    wrSc ? regWdata[CLKSEL_HI:CLKSEL_LO] : clkSel_ff;
  wire logic [2:0] nxt_prescale =
    wrSc ? regWdata[PRESCALE_HI:PRESCALE_LO] : prescale_ff;
  wire logic [NUM_CHAN-1:0] nxt_chanIrqEn =
    wrEn ? enWrVec[NUM_CHAN-1:0] : chanIrqEn_ff;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovfIrqEn_ff <= BIT_RST;
    end else begin
      ovfIrqEn_ff <= nxt_ovfIrqEn;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      centerAlign_ff <= BIT_RST;
    end else begin
      centerAlign_ff <= nxt_centerAlign;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkSel_ff <= CLKSEL_RST;
    end else begin
      clkSel_ff <= nxt_clkSel;
    end
  end

  // The prescaler reads this register directly, so a new factor acts next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale_ff <= PRESCALE_RST;
    end else begin
      prescale_ff <= nxt_prescale;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chanIrqEn_ff <= '0;
    end else begin
      chanIrqEn_ff <= nxt_chanIrqEn;
    end
  end

  // ----------------------------------------------------------------
  // Flag, arming and read data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_ff <= '0;
    end else begin
      armed_ff <= nxt_armed;
    end
  end

  // Data stand only in the cycle after the read, so stale reads show zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= RDATA_RST;
    end else begin
      rdata_ff <= regRd ? readMux : RDATA_RST;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Static level: stays up until software clears the flag or the enable
  wire logic [NFLAG-1:0] irqEnVec = {ovfIrqEn_ff, chanIrqEn_ff};
  assign irq = |(flag_ff & irqEnVec);

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata = rdata_ff;
  assign centerAlignSelect = centerAlign_ff;
  assign clockSourceSelect = clkSel_ff;
  assign prescaleSelect = prescale_ff;

  // ----------------------------------------------------------------
  // Clock source selection, synchronisation and prescaler
  // ----------------------------------------------------------------
  tsc_clock_path uClockPath (
    .clk(clk),
    .rstn(rstn),
    .clockSourceSelect(clkSel_ff),
    .prescaleSelect(prescale_ff),
    .extClkPin(extClkPin),
    .fixedClkTick(fixedClkTick),
    .fixedClkActive(fixedClkActive),
    .countTick(countTick)
  );
endmodule : tsc_timer_status_control

// ---- tsc_timer_status_control_assertions.sv ----
// Port checker for the timer status/control block
`timescale 1ns/1ps
module tsc_timer_status_control_chk
  import tsc_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [tsc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tsc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [tsc_pkg::DATA_W-1:0] regRdata,
  input wire logic overflowEvent,
  input wire logic [NUM_CHAN-1:0] channelEvent,
  input wire logic countTick,
  input wire logic centerAlignSelect,
  input wire logic [1:0] clockSourceSelect,
  input wire logic [2:0] prescaleSelect,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Three cycles of margin cover the source and prescale pipeline
  sequence srcOff3;
    (clockSourceSelect == TSC_SRC_OFF)[*3];
  endsequence
  sequence busFast3;
    (clockSourceSelect == TSC_SRC_BUS && prescaleSelect == 3'h0)[*3];
  endsequence
  sequence busSlow3;
    (clockSourceSelect == TSC_SRC_BUS && prescaleSelect != 3'h0)[*3];
  endsequence
  sequence fastBusWrite;
    regWr && regAddr == ADDR_STATUS_CONTROL && regWdata[4:0] == 5'h08;
  endsequence
  rd_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not zero outside read answer");
  ctrl_readback_a: assert property (regRd && regAddr == ADDR_STATUS_CONTROL |=>
    regRdata[5:0] == {centerAlignSelect, clockSourceSelect, prescaleSelect})
    else $error("control read back wrong");
  unmapped_read_a: assert property (regRd && regAddr > ADDR_IRQ_CLEAR |=>
    regRdata == UNMAPPED_RDATA) else $error("unmapped read not zero");
  ctrl_write_a: assert property (regWr && regAddr == ADDR_STATUS_CONTROL |=>
    {2'b00, centerAlignSelect, clockSourceSelect, prescaleSelect} == ($past(regWdata) & 8'h3f))
    else $error("control write not taken");
  ctrl_hold_a: assert property (!$past(regWr) |->
    $stable({centerAlignSelect, clockSourceSelect, prescaleSelect}))
    else $error("control changed without write");
  irq_rise_cause_a: assert property ($rose(irq) |->
    $past(overflowEvent) || $past(channelEvent) != '0 || $past(regWr))
    else $error("irq rose without event or write");
  irq_fall_cause_a: assert property ($fell(irq) |-> $past(regWr))
    else $error("irq fell without write");
  tick_off_a: assert property (srcOff3 |-> !countTick)
    else $error("count tick with source off");
  tick_bus_a: assert property (busFast3 |-> countTick)
    else $error("missing tick at bus rate");
  tick_gap_a: assert property (busSlow3 |-> !(countTick && $past(countTick)))
    else $error("back to back ticks while dividing");
  presc_apply_a: assert property (fastBusWrite |=> ##1 countTick)
    else $error("new prescale not applied next cycle");
endmodule : tsc_timer_status_control_chk

bind tsc_timer_status_control tsc_timer_status_control_chk #(.NUM_CHAN(NUM_CHAN)) u_chk (
  .clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .overflowEvent,
  .channelEvent, .countTick, .centerAlignSelect, .clockSourceSelect, .prescaleSelect, .irq);

// ---- tb_top.sv ----
// Self-checking testbench for the timer status/control block
`timescale 1ns/1ps
module tb_top;
  import tsc_pkg::*;
  logic clk, rstn, regWr, regRd, overflowEvent, extClkPin, fixedClkTick, fixedClkActive;
  logic countTick, centerAlignSelect, irq;
  logic [3:0] regAddr, channelEvent, ch;
  logic [7:0] regWdata, regRdata;
  logic [1:0] clockSourceSelect;
  logic [2:0] prescaleSelect;
  int failures, checkCount, cyc, ticks;
  tsc_timer_status_control #(.NUM_CHAN(4)) u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .overflowEvent(overflowEvent), .channelEvent(channelEvent), .extClkPin(extClkPin),
    .fixedClkTick(fixedClkTick), .fixedClkActive(fixedClkActive), .countTick(countTick),
    .centerAlignSelect(centerAlignSelect), .clockSourceSelect(clockSourceSelect),
    .prescaleSelect(prescaleSelect), .irq(irq));
  // ----------------------------------------------------------------
  // Clock, free-running sources and timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    extClkPin <= cyc[2];
    fixedClkTick <= (cyc[1:0] == 2'h0);
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checkCount++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk($sformatf("reg%0h", a), e, regRdata);
  endtask : rdc
  task pulse(input logic [4:0] ev);
    @(posedge clk);
    overflowEvent <= ev[4];
    channelEvent <= ev[3:0];
    @(posedge clk);
    overflowEvent <= 1'b0;
    channelEvent <= 4'h0;
  endtask : pulse
  task chkIrq(input logic e);
    #1 chk("irq", {7'h00, e}, {7'h00, irq});
  endtask : chkIrq
  task count(input int n, input int e);
    repeat (4) @(posedge clk);
    ticks = 0;
    repeat (n) begin
      @(posedge clk);
      #1 if (countTick === 1'b1) ticks++;
    end
    chk("ticks", e[7:0], ticks[7:0]);
  endtask : count
  task final_report;
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, regWr, regRd, overflowEvent, fixedClkActive} = 5'h00;
    regAddr = 4'h0;
    regWdata = 8'h00;
    channelEvent = 4'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdc(ADDR_STATUS_CONTROL, 8'h00);
    chkIrq(1'b0);
    wr(ADDR_STATUS_CONTROL, 8'hff);
    #1 chk("ctrl", 8'h3f, {2'b00, centerAlignSelect, clockSourceSelect, prescaleSelect});
    rdc(ADDR_STATUS_CONTROL, 8'h7f);
    rdc(4'h5, 8'h00);
    wr(ADDR_STATUS_CONTROL, 8'h40);
    pulse(5'h10);
    chkIrq(1'b1);
    rdc(ADDR_STATUS_CONTROL, 8'hc0);
    wr(ADDR_STATUS_CONTROL, 8'hc0);
    wr(ADDR_STATUS_CONTROL, 8'h40);
    rdc(ADDR_STATUS_CONTROL, 8'hc0);
    wr(ADDR_STATUS_CONTROL, 8'h40);
    rdc(ADDR_STATUS_CONTROL, 8'h40);
    chkIrq(1'b0);
    pulse(5'h10);
    rdc(ADDR_STATUS_CONTROL, 8'hc0);
    pulse(5'h10);
    wr(ADDR_STATUS_CONTROL, 8'h40);
    rdc(ADDR_STATUS_CONTROL, 8'hc0);
    wr(ADDR_STATUS_CONTROL, 8'h00);
    pulse(5'h10);
    chkIrq(1'b0);
    rdc(ADDR_IRQ_STATUS, 8'h80);
    wr(ADDR_IRQ_CLEAR, 8'h80);
    rdc(ADDR_IRQ_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ch = 4'h1 << i;
      pulse({1'b0, ch});
      chkIrq(1'b0);
      wr(ADDR_IRQ_ENABLE, {4'h0, ch});
      chkIrq(1'b1);
      rdc(ADDR_CHAN_FLAGS, {4'h0, ch});
      wr(ADDR_CHAN_FLAGS, 8'h00);
      chkIrq(1'b0);
      wr(ADDR_IRQ_ENABLE, 8'h00);
    end
    wr(ADDR_STATUS_CONTROL, 8'h00);
    count(32, 0);
    for (int p = 0; p < 8; p++) begin
      wr(ADDR_STATUS_CONTROL, {5'h01, p[2:0]});
      count(128, 128 >> p);
    end
    wr(ADDR_STATUS_CONTROL, 8'h10);
    count(32, 32);
    @(posedge clk);
    fixedClkActive <= 1'b1;
    count(32, 8);
    wr(ADDR_STATUS_CONTROL, 8'h18);
    count(64, 8);
    final_report();
  end
endmodule : tb_top
